//--- rtl/bus_event_flags_regs.vh
// Functional notes
// - Acknowledge flag sets when data is low at the ninth clock rising edge.
// - Acknowledge flag clears on stop, next first clock, exit, disable, reset.
// - Wait release after ninth clock in transmit clears direction, floats data.
// - Start flag sets on start; marks the address byte period.
// - Start flag clears on stop, first clock after address, exit, disable, reset.
// - Stop flag sets on stop; the bus is free again.
// - Stop flag clears at address first clock after start, disable, or reset.
// - Direction one drives the output latch onto data; zero floats it.
`ifndef BUS_EVENT_FLAGS_REGS_VH
`define BUS_EVENT_FLAGS_REGS_VH
`define ACK_CLOCK_NUM   4'h9
`define FIRST_CLOCK_NUM 4'h1
`define BIT_CNT_RESET   4'h0
`define FLAG_RESET      1'b0
`endif

//--- rtl/bus_event_flags.v
`timescale 1ns/1ns
`include "bus_event_flags_regs.vh"
module bus_event_flags (
	input  wire clk,
	input  wire rst_n,
	input  wire serial_clock_pin,
	input  wire serial_data_pin,
	input  wire bus_unit_on,
	input  wire comm_exit_cmd,
	input  wire wait_release_cmd,
	input  wire dir_set_cmd,
	input  wire out_latch_bit,
	output reg  ack_seen_flag,
	output reg  start_seen_flag,
	output reg  stop_seen_flag,
	output reg  transmit_direction_flag,
	output reg  sda_out,
	output reg  sda_oe
);

	// Line index for the synchroniser loop: clock first, then data
	localparam LINE_SCL = 0;
	localparam LINE_SDA = 1;
	localparam LINES    = 2;

	// Raw pins gathered so one loop serves both lines
	wire [LINES-1:0] pin_raw;
	// Second stage; the only synchronised level that logic may read
	wire [LINES-1:0] pin_sync;
	// History of the second stage, used to find edges
	wire [LINES-1:0] pin_prev;

	reg [3:0] bit_cnt_q;
	reg       addr_phase_q;
	reg       addr_done_q;
	reg       wait9_q;
	reg       dir_d;

	// Pins into the loop
	assign pin_raw[LINE_SCL] = serial_clock_pin;
	assign pin_raw[LINE_SDA] = serial_data_pin;

	// Two-stage synchronisers plus a history stage, one per bus line.
	// Reset to one: an idle bus is pulled high, so no false edge
	// appears when reset is released.
	genvar gi;
	generate
		for (gi = 0; gi < LINES; gi = gi + 1) begin : g_sync
			reg meta_q;
			reg sync_q;
			reg prev_q;
			// First stage may be metastable; only sync_q reads it
			always @(posedge clk) begin
				if (!rst_n) begin
					meta_q <= 1'b1;
					sync_q <= 1'b1;
					prev_q <= 1'b1;
				end else begin
					meta_q <= pin_raw[gi];
					sync_q <= meta_q;
					prev_q <= sync_q;
				end
			end
			assign pin_sync[gi] = sync_q;
			assign pin_prev[gi] = prev_q;
		end
	endgenerate

	// Short names for the synchronised levels and their history
	wire scl_now = pin_sync[LINE_SCL];
	wire scl_was = pin_prev[LINE_SCL];
	wire sda_now = pin_sync[LINE_SDA];
	wire sda_was = pin_prev[LINE_SDA];

	// Bus events seen through the synchronised lines.
	// Start and stop need the clock high on both samples, so a data
	// change that lands with a clock fall is never taken for one.
	wire scl_rise = scl_now & ~scl_was;
	wire scl_fall = ~scl_now & scl_was;
	wire start_ev = scl_now & scl_was & ~sda_now & sda_was;
	wire stop_ev  = scl_now & scl_was & sda_now & ~sda_was;

	// Clock position within the byte, counted from zero
	wire cnt_first = (bit_cnt_q == `BIT_CNT_RESET);
	wire cnt_ninth = (bit_cnt_q == (`ACK_CLOCK_NUM - `FIRST_CLOCK_NUM));
	wire first_ck  = scl_rise & cnt_first;
	wire ninth_ck  = scl_rise & cnt_ninth;

	// Disabling the unit acts as a clear for every flag
	wire clr_all  = ~bus_unit_on;
	// A release only counts while the ninth-clock wait is held
	wire rel_hit  = wait_release_cmd & wait9_q;

	// Clock counter; wraps after the ninth so the next rise is a first clock
	always @(posedge clk) begin
		if (!rst_n || clr_all || start_ev || stop_ev) begin
			bit_cnt_q <= `BIT_CNT_RESET;
		end else if (scl_rise) begin
			if (bit_cnt_q == (`ACK_CLOCK_NUM - 4'h1))
				bit_cnt_q <= `BIT_CNT_RESET;
			else
				bit_cnt_q <= bit_cnt_q + `FIRST_CLOCK_NUM;
		end
	end

	// Address byte tracking: completed once its ninth clock passes
	always @(posedge clk) begin
		if (!rst_n || clr_all || stop_ev) begin
			addr_phase_q <= 1'b0;
			addr_done_q  <= 1'b0;
		end else if (start_ev) begin
			addr_phase_q <= 1'b1;
			addr_done_q  <= 1'b0;
		end else if (ninth_ck && addr_phase_q) begin
			addr_phase_q <= 1'b0;
			addr_done_q  <= 1'b1;
		end else if (first_ck) begin
			addr_done_q  <= 1'b0;
		end
	end

	// Ack, start and stop flags below have no write path at all, so software cannot
	// alter them; they change only on bus events and clears

	// Acknowledge flag; the ninth-clock set wins over an exit clear (a disable still wins) in the
	// same cycle, so a late exit command cannot hide an ack
	always @(posedge clk) begin
		if (!rst_n || clr_all) begin
			ack_seen_flag <= `FLAG_RESET;
		end else if (ninth_ck && !sda_now) begin
			ack_seen_flag <= 1'b1;
		end else if (stop_ev || first_ck || comm_exit_cmd) begin
			ack_seen_flag <= 1'b0;
		end
	end

	// Start flag; stays up through the whole address byte
	always @(posedge clk) begin
		if (!rst_n || clr_all) begin
			start_seen_flag <= `FLAG_RESET;
		end else if (start_ev) begin
			start_seen_flag <= 1'b1;
		end else if (stop_ev || comm_exit_cmd ||
			(first_ck && addr_done_q)) begin
			start_seen_flag <= 1'b0;
		end
	end

	// Stop flag; the exit command deliberately leaves it alone
	always @(posedge clk) begin
		if (!rst_n || clr_all) begin
			stop_seen_flag <= `FLAG_RESET;
		end else if (stop_ev) begin
			stop_seen_flag <= 1'b1;
		end else if (first_ck && addr_phase_q) begin
			stop_seen_flag <= 1'b0;
		end
	end

	// Wait state after the ninth clock falls, until released
	always @(posedge clk) begin
		if (!rst_n || clr_all || stop_ev || wait_release_cmd)
			wait9_q <= 1'b0;
		else if (scl_fall && cnt_first && (addr_done_q | ack_seen_flag))
			wait9_q <= 1'b1;
	end

	// Next direction value; the pin enable registers the same value,
	// so the line is never driven while the flag reads receive
	always @* begin
		dir_d = transmit_direction_flag;
		if (clr_all || stop_ev || comm_exit_cmd)
			dir_d = 1'b0;
		else if (rel_hit && transmit_direction_flag)
			dir_d = 1'b0;
		else if (dir_set_cmd)
			dir_d = 1'b1;
	end

	// Direction flag register
	always @(posedge clk) begin
		if (!rst_n)
			transmit_direction_flag <= 1'b0;
		else
			transmit_direction_flag <= dir_d;
	end

	// Pin drive registered; enable moves with the flag, not after it
	always @(posedge clk) begin
		if (!rst_n) begin
			sda_out <= 1'b1;
			sda_oe  <= 1'b0;
		end else begin
			sda_out <= out_latch_bit;
			sda_oe  <= dir_d;
		end
	end

endmodule

//--- test/bus_master_model.sv
`timescale 1ns/1ns
module bus_master_model(output logic scl, sda);
	initial {scl, sda} = 2'h3; // Idle bus, pulled high
	task start; sda = 0; #40 scl = 0; endtask
	// Msb first, 80 ns per bit
	task bits(input [8:0] b, int k);
		for (int i = k - 1; i >= 0; i--) begin
			sda = b[i]; #40 scl = 1; #40 scl = 0;
		end
	endtask
	task stop; sda = 0; #40 scl = 1; #40 sda = 1; #60; endtask
endmodule

//--- test/bus_event_flags_properties.sv
`timescale 1ns/1ns
module bus_event_flags_properties(input wire clk, rst_n, bus_unit_on,
	comm_exit_cmd, wait_release_cmd, out_latch_bit, ack_seen_flag,
	start_seen_flag, stop_seen_flag, transmit_direction_flag, sda_out, sda_oe);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence ex; comm_exit_cmd && bus_unit_on; endsequence
	a_off_clear: assert property (!bus_unit_on |=>
		!(ack_seen_flag | start_seen_flag | stop_seen_flag)) else $error("off");
	a_exit_ack: assert property (ex |=> !ack_seen_flag)
		else $error("ack");
	a_exit_start: assert property (ex |=> !start_seen_flag)
		else $error("start");
	a_exit_stop: assert property (ex ##0 stop_seen_flag |=>
		stop_seen_flag) else $error("stop kept");
	a_stop_alone: assert property ($rose(stop_seen_flag) |->
		!start_seen_flag && !ack_seen_flag) else $error("stop");
	a_rx_float: assert property (!transmit_direction_flag |-> !sda_oe)
		else $error("float");
	a_latch_copy: assert property (sda_oe |->
		sda_out == $past(out_latch_bit)) else $error("latch");
	a_release_tx: assert property (wait_release_cmd &&
		transmit_direction_flag |=> !transmit_direction_flag && !sda_oe)
		else $error("release");
endmodule
bind bus_event_flags bus_event_flags_properties u_prop(.*);

//--- test/testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
$display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench;
	logic clk = 0, rst_n = 0, on = 1, ex = 0, rel = 0, ds = 0, lat = 1;
	wire scl, ms, oe, so, ack, st, sp, dir;
	int fail_count = 0, tests_run = 0;
	always #5 clk = ~clk;
	bus_master_model m(.scl(scl), .sda(ms));
	// Open drain data line: low wins
	bus_event_flags dut(.clk(clk), .rst_n(rst_n), .serial_clock_pin(scl),
		.serial_data_pin(ms & (so | !oe)), .bus_unit_on(on),
		.comm_exit_cmd(ex), .wait_release_cmd(rel), .dir_set_cmd(ds),
		.out_latch_bit(lat), .ack_seen_flag(ack), .start_seen_flag(st),
		.stop_seen_flag(sp), .transmit_direction_flag(dir), .sda_out(so),
		.sda_oe(oe));
	task n(int k); repeat (k) @(negedge clk); endtask
	task automatic p(ref logic s); s = 1; n(1); s = 0; n(4); endtask
	task wrap_up;
		$display("fails %0d checks %0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		n(6); rst_n = 1; n(1); `CHK({ack, st, sp, oe}, 4'h0)
		m.start(); n(3); `CHK(st, 1'b1)
		m.bits(9'h140, 9); n(3); `CHK(ack, 1'b1)
		p(ds); lat = 0; n(2); `CHK({dir, oe, so}, 3'h6)
		lat = 1; p(rel); `CHK({dir, oe}, 2'h0)
		m.bits(1, 1); n(3); `CHK({ack, st}, 2'h0)
		m.bits(0, 8); n(3); `CHK(ack, 1'b1)
		m.stop(); `CHK({ack, st, sp}, 3'h1)
		p(ex); `CHK(sp, 1'b1)
		m.start(); m.bits(1, 1); n(3); `CHK({st, sp}, 2'h2)
		p(ex); `CHK(st, 1'b0)
		m.stop(); on = 0; n(2); `CHK(sp, 1'b0)
		wrap_up();
	end
endmodule
